//--- hw/prs_sequencer.sv
// Function
// - Enable bit set hands fabric configuration inputs to the manager.
// - Writing one to the pulse count emits one configuration clock pulse.
// - Writing three emits exactly three configuration clock pulses.
// - Data-path enable set forwards bus-written words to the fabric.
// - Four monitor flags report done, ready, error and checksum error.
// - Data-path enable cleared stops forwarding bus words.
// - Fabric request output follows the request control bit while the enable bit is set.
// - Writing 128 emits 128 configuration clock pulses.
// - Pulse done flag sets once all requested pulses are sent.
// - Writing one to the pulse done flag clears it.
// - Enable bit cleared hands configuration inputs back to the pins.
`timescale 1ns/100ps
`include "prs_consts.svh"
module prs_sequencer
  import prs_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int CFG_W = 16
)
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  input wire logic pin_cfg_clk_i,
  input wire logic [CFG_W-1:0] pin_cfg_data_i,
  input wire logic pin_cfg_valid_i,
  input wire logic user_mode_i,
  input wire logic partial_done_flag_i,
  input wire logic partial_ready_flag_i,
  input wire logic partial_error_flag_i,
  input wire logic crc_error_flag_i,
  output logic fabric_partial_request_o,
  output logic configuration_clock_pulse_o,
  output logic [CFG_W-1:0] cfg_data_o,
  output logic cfg_data_valid_o,
  output logic cfg_wide_o,
  output logic mgr_owns_o
);
  logic [DATA_W-1:0] ctrl_ff;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  logic [CFG_W-1:0] data_ff, nxt_data;
  logic valid_ff, nxt_valid;
  prs_mon_t mon_s1_ff, mon_s2_ff;
  logic um_s1_ff, um_s2_ff;
  logic pclk_s1_ff, pclk_s2_ff;
  logic pulse, pdone, pbusy;
  prs_fab_ctl_t fab;

  // Register decode
  wire logic wr_ctrl = reg_wr_i && reg_addr_i == `PRS_ADDR_CTRL;
  wire logic wr_pcnt = reg_wr_i && reg_addr_i == `PRS_ADDR_PCNT;
  wire logic wr_pstat = reg_wr_i && reg_addr_i == `PRS_ADDR_PSTAT;
  wire logic wr_data = reg_wr_i && reg_addr_i == `PRS_ADDR_DATA;
  wire logic clr_done = wr_pstat && reg_wdata_i[`PRS_PSTAT_DONE];
  wire logic en = ctrl_ff[`PRS_CTRL_EN];
  wire logic dataen = ctrl_ff[`PRS_CTRL_DATAEN];

  // Pin clock, user mode and monitor flags: two flops before any use; pin data and valid pass straight through
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      mon_s1_ff <= '0;
      mon_s2_ff <= '0;
      um_s1_ff <= 1'b0;
      um_s2_ff <= 1'b0;
      pclk_s1_ff <= 1'b0;
      pclk_s2_ff <= 1'b0;
    end
    else
    begin
      mon_s1_ff <= {crc_error_flag_i, partial_error_flag_i,
                    partial_ready_flag_i, partial_done_flag_i};
      mon_s2_ff <= mon_s1_ff;
      um_s1_ff <= user_mode_i;
      um_s2_ff <= um_s1_ff;
      pclk_s1_ff <= pin_cfg_clk_i;
      pclk_s2_ff <= pclk_s1_ff;
    end
  end

  // Control register; processor reset aborts everything
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      ctrl_ff <= DATA_W'(`PRS_CTRL_RESET);
    else if (wr_ctrl)
      ctrl_ff <= reg_wdata_i & DATA_W'(32'h0000_000F);
  end

  prs_pulse_gen #(
    .CNT_W(DATA_W)
  ) u_pulse (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .load_i(wr_pcnt),
    .count_i(reg_wdata_i),
    .clr_done_i(clr_done),
    .pulse_o(pulse),
    .done_o(pdone),
    .busy_o(pbusy)
  );

  // Bus words go to the fabric only while data path is enabled
  assign nxt_valid = wr_data && dataen && en;
  assign nxt_data = nxt_valid ? reg_wdata_i[CFG_W-1:0] : data_ff;

  // Fabric control bundle: owned is the enable bit, request is gated by it, width is not
  assign fab.owned = en;
  assign fab.wide = ctrl_ff[`PRS_CTRL_WIDTH];
  assign fab.request = en && ctrl_ff[`PRS_CTRL_REQ];

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    nxt_rdata = '0;
    case (reg_addr_i)
      `PRS_ADDR_CTRL: nxt_rdata = ctrl_ff;
      `PRS_ADDR_STAT: nxt_rdata = DATA_W'({pbusy, um_s2_ff});
      `PRS_ADDR_PSTAT: nxt_rdata = DATA_W'(pdone);
      `PRS_ADDR_MON: nxt_rdata = DATA_W'(mon_s2_ff);
      default: nxt_rdata = '0;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      rdata_ff <= '0;
      data_ff <= '0;
      valid_ff <= 1'b0;
    end
    else
    begin
      rdata_ff <= reg_rd_i ? nxt_rdata : '0;
      data_ff <= nxt_data;
      valid_ff <= nxt_valid;
    end
  end

  // Pins drive the fabric when the manager has no control
  assign reg_rdata_o = rdata_ff;
  assign mgr_owns_o = fab.owned;
  assign cfg_wide_o = fab.wide;
  assign fabric_partial_request_o = fab.request;
  assign configuration_clock_pulse_o = fab.owned ? pulse : pclk_s2_ff;
  assign cfg_data_o = fab.owned ? data_ff : pin_cfg_data_i;
  assign cfg_data_valid_o = fab.owned ? valid_ff : pin_cfg_valid_i;

  a_req_follow: assert property (@(posedge clk_sys_i)
    disable iff (!rstn_i)
    wr_ctrl && reg_wdata_i[`PRS_CTRL_EN] |=>
    fabric_partial_request_o == $past(reg_wdata_i[`PRS_CTRL_REQ]))
    else $error("request does not follow control bit");
  a_data_forward: assert property (@(posedge clk_sys_i)
    disable iff (!rstn_i)
    wr_data && dataen && en |=> cfg_data_valid_o &&
    cfg_data_o == $past(reg_wdata_i[CFG_W-1:0]))
    else $error("data word not forwarded");
  a_data_block: assert property (@(posedge clk_sys_i)
    disable iff (!rstn_i)
    en && !dataen |=> !valid_ff)
    else $error("data forwarded while disabled");
  a_pins_back: assert property (@(posedge clk_sys_i)
    disable iff (!rstn_i)
    !en |-> cfg_data_o == pin_cfg_data_i && !fabric_partial_request_o)
    else $error("pins not handed back");
  a_mgr_take: assert property (@(posedge clk_sys_i)
    disable iff (!rstn_i)
    wr_ctrl && reg_wdata_i[`PRS_CTRL_EN] |=> mgr_owns_o)
    else $error("manager did not take control");
  // Busy spans four cycles per pulse, then drops
  a_one_pulse: assert property (@(posedge clk_sys_i)
    disable iff (!rstn_i)
    wr_pcnt && reg_wdata_i == DATA_W'(1) && !pbusy && en |=>
    pbusy [*4] ##1 !pbusy)
    else $error("single pulse wrong length");
  a_mon_report: assert property (@(posedge clk_sys_i)
    disable iff (!rstn_i)
    reg_rd_i && reg_addr_i == `PRS_ADDR_MON |=>
    reg_rdata_o[3:0] == $past(mon_s2_ff))
    else $error("monitor flags misreported");
  // Twelve busy cycles for three pulses, split to keep repeats short
  a_three_pulses: assert property (@(posedge clk_sys_i)
    disable iff (!rstn_i)
    wr_pcnt && reg_wdata_i == DATA_W'(3) && !pbusy |=> pbusy [*8]
    ##1 pbusy [*4] ##1 !pbusy)
    else $error("three pulses wrong length");
endmodule

//--- hw/prs_consts.svh
`ifndef PRS_CONSTS_SVH
`define PRS_CONSTS_SVH

// Register word addresses on the plain register port
`define PRS_ADDR_CTRL 4'h0
`define PRS_ADDR_STAT 4'h1
`define PRS_ADDR_PCNT 4'h2
`define PRS_ADDR_PSTAT 4'h3
`define PRS_ADDR_DATA 4'h4
`define PRS_ADDR_MON 4'h5

// Control register fields
`define PRS_CTRL_EN 0
`define PRS_CTRL_WIDTH 1
`define PRS_CTRL_REQ 2
`define PRS_CTRL_DATAEN 3
`define PRS_CTRL_RESET 32'h0000_0002

// Pulse status field
`define PRS_PSTAT_DONE 0

// Monitor fields
`define PRS_MON_DONE 0
`define PRS_MON_READY 1
`define PRS_MON_ERROR 2
`define PRS_MON_CRC 3

// Pulse timing: half period of the configuration clock pulse
`define PRS_HALF_NS 100
`define PRS_CLK_NS 50
`define PRS_HALF_CYC ((`PRS_HALF_NS + `PRS_CLK_NS - 1) / `PRS_CLK_NS)

`endif

//--- hw/prs_pkg.sv
package prs_pkg;
  // Fabric-facing control bundle
  typedef struct packed {
    logic owned;
    logic wide;
    logic request;
  } prs_fab_ctl_t;

  // Monitor flags coming back from the fabric
  typedef struct packed {
    logic crc;
    logic error;
    logic ready;
    logic done;
  } prs_mon_t;
endpackage

//--- hw/prs_pulse_gen.sv
`timescale 1ns/100ps
`include "prs_consts.svh"
module prs_pulse_gen
  import prs_pkg::*;
#(
  parameter int CNT_W = 32
)
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic load_i,
  input wire logic [CNT_W-1:0] count_i,
  input wire logic clr_done_i,
  output logic pulse_o,
  output logic done_o,
  output logic busy_o
);
  typedef enum logic [1:0] {PG_IDLE, PG_HIGH, PG_LOW} prs_pg_state_t;

  localparam logic [7:0] HALF = 8'(`PRS_HALF_CYC);

  prs_pg_state_t state_ff, nxt_state;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [7:0] tmr_ff, nxt_tmr;
  logic done_ff, nxt_done;
  logic pulse_ff;
  wire logic tmr_end = (tmr_ff == 8'h01);
  wire logic last = (cnt_ff == CNT_W'(1));

  // One pulse per decrement, done when count reaches zero
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_tmr = tmr_end ? tmr_ff : tmr_ff - 8'h01;
    case (state_ff)
      PG_IDLE:
      begin
        if (load_i && count_i != '0)
        begin
          nxt_cnt = count_i;
          nxt_tmr = HALF;
          nxt_state = PG_HIGH;
        end
      end
      PG_HIGH:
      begin
        if (tmr_end)
        begin
          nxt_tmr = HALF;
          nxt_state = PG_LOW;
        end
      end
      PG_LOW:
      begin
        if (tmr_end)
        begin
          nxt_cnt = cnt_ff - CNT_W'(1);
          nxt_tmr = HALF;
          nxt_state = last ? PG_IDLE : PG_HIGH;
        end
      end
      default:
        nxt_state = PG_IDLE;
    endcase
  end

  // Set wins over a simultaneous write-one clear
  assign nxt_done = (state_ff == PG_LOW && tmr_end && last) ? 1'b1
                  : (clr_done_i ? 1'b0 : done_ff);

  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      state_ff <= PG_IDLE;
      cnt_ff <= '0;
      tmr_ff <= 8'h00;
      done_ff <= 1'b0;
      pulse_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      tmr_ff <= nxt_tmr;
      done_ff <= nxt_done;
      pulse_ff <= (nxt_state == PG_HIGH);
    end
  end

  assign pulse_o = pulse_ff;
  assign done_o = done_ff;
  assign busy_o = (state_ff != PG_IDLE);

  a_pulse_width: assert property (@(posedge clk_sys_i)
    disable iff (!rstn_i)
    $rose(pulse_o) |-> pulse_o [*2] ##1 !pulse_o)
    else $error("pulse high time wrong");
  a_done_after_pulse: assert property (@(posedge clk_sys_i)
    disable iff (!rstn_i)
    $rose(done_o) |-> !busy_o && $past(busy_o))
    else $error("done without finishing pulses");
  a_done_clear: assert property (@(posedge clk_sys_i)
    disable iff (!rstn_i)
    clr_done_i && done_o && !(state_ff == PG_LOW && tmr_end) |=> !done_o)
    else $error("done not cleared");
endmodule

//--- dv/prs_fab_model.sv
`timescale 1ns/100ps
module prs_fab_model
  import prs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic req_i,
  input wire logic pulse_i,
  input wire logic valid_i,
  input wire logic [1:0] mode_i,
  output prs_mon_t mon_o
);
  localparam int WORDS = 4;
  logic pulse_ff;
  logic [4:0] npul_ff;
  logic [3:0] nwd_ff;
  // Flags move only on pulse edges and words, as the fabric would
  always @(posedge clk_i)
  begin
    pulse_ff <= pulse_i;
    if (!rstn_i)
    begin
      mon_o <= '0;
      npul_ff <= '0;
      nwd_ff <= '0;
    end
    else if (pulse_i && !pulse_ff && req_i)
    begin
      if (npul_ff < 16)
        npul_ff <= npul_ff + 1;
      if (npul_ff == 15)
        mon_o.ready <= 1'b1;
    end
    else if (pulse_i && !pulse_ff)
    begin
      mon_o <= '0;
      npul_ff <= '0;
      nwd_ff <= '0;
    end
    else if (valid_i && req_i && mon_o.ready)
    begin
      nwd_ff <= nwd_ff + 1;
      if (nwd_ff == WORDS - 1)
      begin
        mon_o.ready <= 1'b0;
        mon_o.done <= (mode_i == 2'h0);
        mon_o.error <= (mode_i == 2'h1);
        mon_o.crc <= (mode_i == 2'h2);
      end
    end
  end
endmodule

//--- dv/test_prs_sequencer.sv
`timescale 1ns/100ps
`include "prs_consts.svh"
module test_prs_sequencer import prs_pkg::*;;
  typedef struct packed {
    logic w;
    logic [3:0] a;
    logic [31:0] d;
  } prs_row_t;
  logic clk = 0;
  logic rstn = 0;
  logic fab_rstn = 0;
  logic [3:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr = 0;
  logic rd = 0;
  logic pin_clk = 0;
  logic [15:0] pin_data = 16'hA5C3;
  logic pin_valid = 1'b1;
  logic [1:0] mode = '0;
  logic [31:0] rdata;
  logic req, pulse, pulse_q, cvalid, wide, owns;
  logic [15:0] cdata;
  prs_mon_t mon;
  int miscompares = 0, compares = 0, cyc = 0, npul = 0, nval = 0, base;
  prs_row_t rows [10] = '{
    '{1'b0, 4'h0, 32'h2}, '{1'b1, 4'hF, 32'h5}, '{1'b0, 4'h0, 32'h2},
    '{1'b0, 4'hF, 32'h0}, '{1'b0, 4'h2, 32'h0}, '{1'b0, 4'h1, 32'h1},
    '{1'b0, 4'h5, 32'h0}, '{1'b1, 4'h0, 32'h1}, '{1'b0, 4'h0, 32'h1},
    '{1'b0, 4'h3, 32'h0}};

  prs_sequencer u_dut (.clk_sys_i(clk), .rstn_i(rstn), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .pin_cfg_clk_i(pin_clk), .pin_cfg_data_i(pin_data),
    .pin_cfg_valid_i(pin_valid), .user_mode_i(1'b1),
    .partial_done_flag_i(mon.done), .partial_ready_flag_i(mon.ready),
    .partial_error_flag_i(mon.error), .crc_error_flag_i(mon.crc),
    .fabric_partial_request_o(req), .configuration_clock_pulse_o(pulse),
    .cfg_data_o(cdata), .cfg_data_valid_o(cvalid), .cfg_wide_o(wide),
    .mgr_owns_o(owns));
  prs_fab_model u_fab (.clk_i(clk), .rstn_i(fab_rstn), .req_i(req),
    .pulse_i(pulse), .valid_i(cvalid), .mode_i(mode), .mon_o(mon));

  always #25 clk = ~clk;
  // Pin clock of 400 ns; pulse and word counters; hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3)
      pin_clk <= ~pin_clk;
    pulse_q <= pulse;
    if (pulse && !pulse_q)
      npul <= npul + 1;
    if (cvalid)
      nval <= nval + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      conclude();
    end
  end

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Bus cycles start right after an edge and leave one edge free
  task automatic wreg(logic [3:0] a, logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
    @(posedge clk);
  endtask
  task automatic rreg(logic [3:0] a, logic [31:0] exp);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 chk("rdata", rdata, exp);
    @(posedge clk);
  endtask
  // A second write while busy must be dropped
  task automatic pulses(int n, bit dup);
    base = npul;
    wreg(`PRS_ADDR_PCNT, n);
    if (dup)
      wreg(`PRS_ADDR_PCNT, n);
    repeat (4 * n + 2) @(posedge clk);
    chk("pulses", npul - base, n);
    rreg(`PRS_ADDR_PSTAT, 32'h1);
    wreg(`PRS_ADDR_PSTAT, 32'h1);
    rreg(`PRS_ADDR_PSTAT, 32'h0);
  endtask
  // Let the edge made by the ownership switch be counted before the window
  task automatic pinchk();
    repeat (2) @(posedge clk);
    base = npul;
    repeat (16) @(posedge clk);
    chk("pinclk", npul - base, 2);
    chk("pindata", cdata, pin_data);
    chk("pinvalid", cvalid, pin_valid);
  endtask
  task automatic run_pr(int m);
    mode <= m[1:0];
    wreg(`PRS_ADDR_CTRL, 32'h5);
    chk("req", req, 1);
    if (m == 0)
      for (int k = 1; k <= 16; k++)
      begin
        pulses(1, 0);
        rreg(`PRS_ADDR_MON, k == 16 ? 32'h2 : 32'h0);
      end
    else
      pulses(16, 0);
    pulses(3, 1);
    wreg(`PRS_ADDR_CTRL, 32'hD);
    base = nval;
    for (int k = 0; k < 4; k++)
      wreg(`PRS_ADDR_DATA, 32'hFFFF_1230 + k);
    repeat (3) @(posedge clk); // Word counter and flag synchronisers settle
    chk("words", nval - base, 4);
    chk("word", cdata, 16'h1233);
    rreg(`PRS_ADDR_MON, 32'h1 << (m ? m + 1 : 0));
    wreg(`PRS_ADDR_CTRL, 32'h5);
    base = nval;
    wreg(`PRS_ADDR_DATA, 32'h7);
    @(posedge clk);
    chk("blocked", nval - base, 0);
    wreg(`PRS_ADDR_CTRL, 32'h1);
    chk("req", req, 0);
    pulses(128, 0);
    rreg(`PRS_ADDR_MON, 32'h0);
  endtask
  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Pin check first, then the table, the full sequences, a second pin check and the reset case
  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1;
    fab_rstn <= 1;
    repeat (3) @(posedge clk);
    pinchk();
    foreach (rows[i])
      if (rows[i].w)
        wreg(rows[i].a, rows[i].d);
      else
        rreg(rows[i].a, rows[i].d);
    chk("owns", owns, 1);
    chk("wide", wide, 0);
    for (int m = 0; m < 3; m++)
      run_pr(m);
    wreg(`PRS_ADDR_CTRL, 32'h0);
    pinchk();
    wreg(`PRS_ADDR_CTRL, 32'hD);
    // Reset lands while a long pulse burst is running
    wreg(`PRS_ADDR_PCNT, 32'h80);
    rstn <= 0;
    repeat (2) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    chk("owns", owns, 0);
    chk("req", req, 0);
    chk("wide", wide, 1);
    rreg(`PRS_ADDR_CTRL, 32'h2);
    rreg(`PRS_ADDR_STAT, 32'h1);
    rreg(`PRS_ADDR_PSTAT, 32'h0);
    conclude();
  end
endmodule
